// ---- design/subcpu_pins.sv ----
// pin control logic of the 8-bit sub processor
//
// Overview of operation
// RULE1: select low enables serial clock and data
// RULE2: select high floats serial output, ignores clock
// RULE3: select as general input keeps serial active
// RULE4: timer flop set by start, cleared by borrow
// RULE5: io_not_mem low during memory access cycles
// RULE6: hold sampled per cycle; float buses, ack
// RULE7: hold low drops ack, resumes next cycle
// RULE8: data bus floats on input, halt, hold, reset
// RULE9: full mode drives address in memory cycles
// RULE10: split mode: low twelve address, top nibble B
// RULE11: wide output drives B high, C low
// RULE12: first_cycle_flag high T1..T3 of opcode fetch
// RULE13: wait low at T2 end inserts wait states
// RULE14: fixed priority level, timer, rise, edge, serial
// RULE15: level_irq high level; rise_irq rising edge
// RULE16: edge_select picks rising or falling edge
// RULE17: interrupt pins filtered by 2 us sampling
// RULE18: half_clock_out is clock divided by two
// RULE19: shift out MSB on fall, capture on rise
// RULE20: reset filtered; start address zero on release
// RULE21: reset clears enable, pending; sets masks
// RULE22: reset loads port, timer, ack defaults
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
module subcpu_pins #(
  parameter int SAMPLE_CYCLES = subcpu_pkg::SAMPLE_CYC,
  parameter int TICK_CYCLES   = subcpu_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  // external reset pin, filtered
  input  wire logic        reset_pin_n,
  // core side: machine cycle requests
  input  wire logic        cyc_start,
  input  wire logic        cyc_mem,
  input  wire logic        cyc_write,
  input  wire logic        cyc_opfetch,
  input  wire logic [15:0] cyc_addr,
  input  wire logic [7:0]  cyc_wdata,
  input  wire logic        halt_req,
  output logic             cyc_done,
  output logic [7:0]       cyc_rdata,
  output logic             halted,
  output logic [15:0]      start_addr,
  output logic             core_reset,
  // core side: commands and registers
  input  wire logic        timer_start_cmd,
  input  wire logic        addr_bus_enable_cmd,
  input  wire logic        split_cmd,
  input  wire logic        wide_output_cmd,
  input  wire logic [7:0]  reg_b,
  input  wire logic [7:0]  reg_c,
  input  wire logic        timer_load,
  input  wire logic [11:0] timer_value,
  input  wire logic        modec_we,
  input  wire logic [7:0]  modec_wdata,
  input  wire logic        mask_we,
  input  wire logic [7:0]  mask_wdata,
  input  wire logic        ie_set,
  input  wire logic        ie_clr,
  input  wire logic        irq_taken,
  input  wire logic        serial_we,
  input  wire logic [7:0]  serial_wdata,
  input  wire logic        serial_rd,
  output logic [7:0]       serial_rdata,
  output logic [4:0]       irq_pending,
  output logic [2:0]       irq_vector,
  output logic             irq_req,
  output logic [7:0]       portb_dir,
  output logic [7:0]       portc_mode,
  output logic [7:0]       port_a,
  // serial pins
  input  wire logic        serial_select_n,
  input  wire logic        serial_clock_n,
  input  wire logic        serial_in,
  output logic             serial_out,
  output logic             serial_out_oe_n,
  output logic             serial_ack,
  // control pins
  output logic             timer_out,
  output logic             io_not_mem,
  input  wire logic        hold_req,
  output logic             hold_ack,
  input  wire logic        wait_n,
  output logic             first_cycle_flag,
  output logic             half_clock_out,
  output logic             rd_n,
  output logic             wr_n,
  output logic             strobe_oe_n,
  // data bus
  input  wire logic [7:0]  db_in,
  output logic [7:0]       db_out,
  output logic             db_oe_n,
  // extension pins
  output logic [15:0]      ext_pins,
  output logic [15:0]      ext_oe_n,
  // interrupt pins
  input  wire logic        level_irq,
  input  wire logic        rise_irq,
  input  wire logic        edge_sel_irq
);
  import subcpu_pkg::*;

  logic [7:0]  samp_cnt_reg;
  logic        samp_tick;
  logic [7:0]  tick_cnt_reg;
  logic        timer_tick;
  logic        rst_lvl;
  logic        rst_sync;
  logic        run;
  logic [2:0]  irq_lvl;
  logic [2:0]  irq_sync;
  logic [2:0]  irq_prev_reg;
  logic        sck_sync;
  logic        sck_prev_reg;
  logic        sel_sync;
  logic        si_sync;
  logic        serial_on;
  logic [7:0]  sreg_reg;
  logic [2:0]  bit_cnt_reg;
  logic [11:0] tcount_reg;
  logic [11:0] treload_reg;
  logic        tborrow;
  logic        ie_reg;
  logic [7:0]  mask_reg;
  logic [4:0]  raw_irq;
  logic        serial_done;
  pe_mode_e    pe_mode_reg;
  cyc_e        cyc_reg;
  logic        mem_reg;
  logic        wr_reg;
  logic        op_reg;
  logic [15:0] addr_reg;
  logic [7:0]  wdata_reg;
  logic        active;
  logic        drive_addr;

  // sample and timer prescale ticks
  always_ff @(posedge clk_sys)
    if (!resetn)
      samp_cnt_reg <= 8'h00;
    else if (ce)
      samp_cnt_reg <= samp_tick ? 8'h00 : samp_cnt_reg + 8'h01;
  assign samp_tick = (samp_cnt_reg == 8'(SAMPLE_CYCLES - 1));

  always_ff @(posedge clk_sys)
    if (!resetn)
      tick_cnt_reg <= 8'h00;
    else if (ce)
      tick_cnt_reg <= timer_tick ? 8'h00 : tick_cnt_reg + 8'h01;
  assign timer_tick = (tick_cnt_reg == 8'(TICK_CYCLES - 1));

  // reset pin ignores glitches shorter than one sample period
  pin_filter u_rst (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .tick    (samp_tick),
    .pin     (reset_pin_n),
    .init    (1'b0),
    .level   (rst_lvl),
    .sync    (rst_sync)
  ); // RULE20
  assign run        = rst_lvl;
  assign core_reset = !run;
  assign start_addr = PC_RST; // RULE20

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_irq
      pin_filter u_irq (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .ce      (ce),
        .tick    (samp_tick),
        .pin     (gi == 0 ? level_irq : (gi == 1 ? rise_irq : edge_sel_irq)),
        .init    (1'b0),
        .level   (irq_lvl[gi]),
        .sync    (irq_sync[gi])
      ); // RULE17
    end
  endgenerate

  // serial pins: sync only, edges must track the clock closely
  pin_filter u_sck (
    .clk_sys (clk_sys), .resetn (resetn), .ce (ce), .tick (1'b0),
    .pin (serial_clock_n), .init (1'b0), .level (), .sync (sck_sync)
  );
  pin_filter u_sel (
    .clk_sys (clk_sys), .resetn (resetn), .ce (ce), .tick (1'b0),
    .pin (serial_select_n), .init (1'b0), .level (), .sync (sel_sync)
  );
  pin_filter u_si (
    .clk_sys (clk_sys), .resetn (resetn), .ce (ce), .tick (1'b0),
    .pin (serial_in), .init (1'b0), .level (), .sync (si_sync)
  );

  assign serial_on = portc_mode[MC_SCS_BIT] || !sel_sync; // RULE1 RULE2 RULE3

  always_ff @(posedge clk_sys)
    if (!resetn || !run)
      sck_prev_reg <= 1'b1;
    else if (ce)
      sck_prev_reg <= sck_sync;

  // serial shifter; a core write takes precedence over a clock edge, a read does not affect it
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
    begin
      sreg_reg    <= 8'h00;
      bit_cnt_reg <= 3'h0;
      serial_out  <= 1'b1;
    end
    else if (ce)
    begin
      if (serial_we)
      begin
        sreg_reg    <= serial_wdata;
        bit_cnt_reg <= 3'h0;
      end
      else if (serial_on && sck_prev_reg && !sck_sync)
        serial_out <= sreg_reg[7]; // RULE19
      else if (serial_on && !sck_prev_reg && sck_sync)
      begin
        sreg_reg    <= {sreg_reg[6:0], si_sync}; // RULE19
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
    end
  assign serial_done = serial_on && !sck_prev_reg && sck_sync && (bit_cnt_reg == 3'h7)
                       && !serial_we;
  assign serial_rdata    = sreg_reg;
  assign serial_out_oe_n = !serial_on; // RULE2

  // ack low after eight bits, high on core access; completion wins over a read, a write wins over completion
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
      serial_ack <= 1'b1; // RULE22
    else if (ce)
    begin
      if (serial_done)
        serial_ack <= 1'b0;
      else if (serial_we || serial_rd)
        serial_ack <= 1'b1;
    end

  // interval timer
  assign tborrow = timer_tick && (tcount_reg == 12'h000);
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
    begin
      tcount_reg  <= TIMER_RST; // RULE22
      treload_reg <= TIMER_RST;
    end
    else if (ce)
    begin
      if (timer_load)
      begin
        treload_reg <= timer_value;
        tcount_reg  <= timer_value;
      end
      else if (tborrow)
        tcount_reg <= treload_reg;
      else if (timer_tick)
        tcount_reg <= tcount_reg - 12'h001;
    end

  // borrow wins over a start in the same cycle would lose a pulse; start wins
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
      timer_out <= 1'b0; // RULE22
    else if (ce)
    begin
      if (timer_start_cmd)
        timer_out <= 1'b1; // RULE4
      else if (tborrow)
        timer_out <= 1'b0; // RULE4
    end

  // mode and mask registers
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
    begin
      portc_mode <= MODEC_RST; // RULE22
      portb_dir  <= MODEB_RST; // RULE22
      port_a     <= 8'h00; // RULE22
      mask_reg   <= MASK_RST; // RULE21
      ie_reg     <= 1'b0; // RULE21
    end
    else if (ce)
    begin
      if (modec_we)
        portc_mode <= modec_wdata;
      if (mask_we)
        mask_reg <= mask_wdata;
      if (ie_set)
        ie_reg <= 1'b1;
      else if (ie_clr || irq_taken)
        ie_reg <= 1'b0;
    end

  // interrupt detection; bit 7 of mask is the edge select, reset to falling
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
      irq_prev_reg <= 3'b000;
    else if (ce)
      irq_prev_reg <= irq_lvl;

  assign raw_irq[0] = irq_lvl[0]; // RULE15
  assign raw_irq[1] = tborrow;
  assign raw_irq[2] = irq_lvl[1] && !irq_prev_reg[1]; // RULE15
  assign raw_irq[3] = mask_reg[7] ? (irq_lvl[2] && !irq_prev_reg[2])
                                  : (!irq_lvl[2] && irq_prev_reg[2]); // RULE16
  assign raw_irq[4] = serial_done;

  // pending flags: new request wins over the acknowledge clear
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
      irq_pending <= 5'h00; // RULE21
    else if (ce)
    begin
      for (int i = 1; i < IRQ_N; i++)
        if (raw_irq[i])
          irq_pending[i] <= 1'b1;
        else if (irq_taken && irq_vector == 3'(i))
          irq_pending[i] <= 1'b0;
      irq_pending[0] <= raw_irq[0];
    end

  always_comb
  begin
    irq_vector = 3'h0;
    for (int i = IRQ_N - 1; i >= 0; i--)
      if (irq_pending[i] && !mask_reg[i])
        irq_vector = 3'(i); // RULE14
  end
  assign irq_req = ie_reg && |(irq_pending & ~mask_reg[4:0]);

  // extension pin mode
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
      pe_mode_reg <= PE_FULL; // RULE9
    else if (ce)
    begin
      if (wide_output_cmd)
        pe_mode_reg <= PE_PORT; // RULE11
      else if (addr_bus_enable_cmd)
        pe_mode_reg <= PE_FULL; // RULE9
      else if (split_cmd && pe_mode_reg != PE_PORT)
        pe_mode_reg <= PE_SPLIT;
    end

  // halt state
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
      halted <= 1'b0; // RULE21
    else if (ce && halt_req)
      halted <= 1'b1;

  // machine cycle sequencer; hold checked at each cycle boundary
  always_ff @(posedge clk_sys)
    if (!resetn || !run)
    begin
      cyc_reg   <= CY_T1;
      mem_reg   <= 1'b0;
      wr_reg    <= 1'b0;
      op_reg    <= 1'b0;
      addr_reg  <= 16'h0000;
      wdata_reg <= 8'h00;
      active    <= 1'b0;
      hold_ack  <= 1'b0; // RULE22
      cyc_rdata <= 8'h00;
    end
    else if (ce)
    begin
      case (cyc_reg)
        CY_T1:
        if (!active && hold_req)
        begin
          cyc_reg  <= CY_HOLD; // RULE6
          hold_ack <= 1'b1; // RULE6
        end
        else if (active)
          cyc_reg <= CY_T2;
        else if (cyc_start && !halted)
        begin
          active    <= 1'b1;
          mem_reg   <= cyc_mem;
          wr_reg    <= cyc_write;
          op_reg    <= cyc_opfetch;
          addr_reg  <= cyc_addr;
          wdata_reg <= cyc_wdata;
        end
        CY_T2:
        cyc_reg <= wait_n ? CY_T3 : CY_TW; // RULE13
        CY_TW:
        if (wait_n)
          cyc_reg <= CY_T3; // RULE13
        CY_T3:
        begin
          cyc_reg   <= CY_T1;
          active    <= 1'b0;
          cyc_rdata <= db_in;
        end
        CY_HOLD:
        if (!hold_req)
        begin
          cyc_reg  <= CY_T1; // RULE7
          hold_ack <= 1'b0; // RULE7
        end
        default:
          cyc_reg <= CY_T1;
      endcase
    end
  assign cyc_done = active && (cyc_reg == CY_T3);

  // pin outputs
  assign io_not_mem       = !(active && mem_reg); // RULE5
  assign first_cycle_flag = active && op_reg && (cyc_reg != CY_HOLD); // RULE12
  assign rd_n             = !(active && !wr_reg && cyc_reg != CY_T1);
  assign wr_n             = !(active && wr_reg && cyc_reg != CY_T1);
  assign strobe_oe_n      = !active;
  assign db_out           = wdata_reg;
  assign db_oe_n          = !(active && wr_reg); // RULE8
  assign drive_addr       = active && mem_reg;

  always_comb
  begin
    ext_pins = addr_reg;
    ext_oe_n = 16'hFFFF;
    case (pe_mode_reg)
      PE_FULL:
        ext_oe_n = {16{!drive_addr}}; // RULE9
      PE_SPLIT:
      begin
        ext_pins = {reg_b[7:4], addr_reg[LOW_PINS-1:0]}; // RULE10
        ext_oe_n = {4'h0, {LOW_PINS{!drive_addr}}}; // RULE10
      end
      PE_PORT:
      begin
        ext_pins = {reg_b, reg_c}; // RULE11
        ext_oe_n = 16'h0000;
      end
      default:
        ext_oe_n = 16'hFFFF;
    endcase
  end

  // clock divided by two
  always_ff @(posedge clk_sys)
    if (!resetn)
      half_clock_out <= 1'b0;
    else if (ce)
      half_clock_out <= !half_clock_out; // RULE18
endmodule : subcpu_pins

// ---- design/subcpu_pkg.sv ----
// constants for the sub processor pin control block
package subcpu_pkg;
  localparam int CLK_MHZ            = 40;
  localparam int SAMPLE_US          = 2;
  localparam int SAMPLE_CYC         = SAMPLE_US * CLK_MHZ;
  localparam int TICK_US            = 4;
  localparam int TICK_CYC           = TICK_US * CLK_MHZ;
  localparam int TIMER_W            = 12;
  localparam logic [11:0] TIMER_RST = 12'hFFF;
  localparam logic [7:0] MODEC_RST  = 8'hFF;
  localparam logic [7:0] MODEB_RST  = 8'hFF;
  localparam logic [7:0] MASK_RST   = 8'h1F;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam int MC_SCS_BIT         = 2;
  localparam int IRQ_N              = 5;
  localparam int LOW_PINS           = 12;
  typedef enum logic [2:0] {
    PE_FULL  = 3'b001,
    PE_SPLIT = 3'b010,
    PE_PORT  = 3'b100
  } pe_mode_e;
  typedef enum logic [4:0] {
    CY_T1   = 5'b00001,
    CY_T2   = 5'b00010,
    CY_TW   = 5'b00100,
    CY_T3   = 5'b01000,
    CY_HOLD = 5'b10000
  } cyc_e;
endpackage : subcpu_pkg

// ---- design/pin_filter.sv ----
// two flop synchroniser plus slow-tick noise filter for one pin
`timescale 1ns/1ps
module pin_filter (
  // clock
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic tick,
  // pin
  input  wire logic pin,
  input  wire logic init,
  output logic      level,
  output logic      sync
);
  logic s1_reg;
  logic s2_reg;
  logic samp_reg;

  always_ff @(posedge clk_sys)
    if (!resetn)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
    end
    else if (ce)
    begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
    end

  assign sync = s2_reg;

  // with init low, level accepted only when two samples one tick apart agree
  always_ff @(posedge clk_sys)
    if (!resetn)
    begin
      samp_reg <= 1'b0;
      level    <= 1'b0;
    end
    else if (ce && init)
    begin
      samp_reg <= s2_reg;
      level    <= s2_reg;
    end
    else if (ce && tick)
    begin
      samp_reg <= s2_reg;
      if (samp_reg == s2_reg)
        level <= s2_reg;
    end
endmodule : pin_filter

// ---- verif/subcpu_pins_chk.sv ----
// port assertions for the pin control block
`timescale 1ns/1ps
module subcpu_pins_chk (
  // clock and reset
  input wire logic        clk_sys, resetn, ce,
  // core side
  input wire logic        cyc_start, cyc_mem, cyc_opfetch, cyc_done, wide_output_cmd, irq_req,
  input wire logic [7:0]  reg_b, reg_c, portb_dir, portc_mode, port_a,
  input wire logic [4:0]  irq_pending,
  input wire logic [2:0]  irq_vector,
  // pins
  input wire logic        serial_select_n, serial_out_oe_n, serial_ack, timer_out, io_not_mem,
  input wire logic        hold_req, hold_ack, wait_n, first_cycle_flag, half_clock_out,
  input wire logic        rd_n, wr_n, strobe_oe_n, db_oe_n,
  input wire logic [15:0] ext_pins, ext_oe_n
);
  import subcpu_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  chk_half_clock: assert property ($past(resetn && ce)
    |-> half_clock_out != $past(half_clock_out))
    else $error("half clock did not toggle");
  chk_serial_float: assert property ((serial_select_n && !portc_mode[MC_SCS_BIT]) [*4] |-> serial_out_oe_n)
    else $error("serial output driven while deselected");
  chk_mem_marker: assert property ($fell(io_not_mem) |-> $past(cyc_start && cyc_mem))
    else $error("memory marker low without memory cycle");
  chk_hold_float: assert property (hold_ack |-> db_oe_n && strobe_oe_n && ext_oe_n[11:0] == 12'hFFF)
    else $error("bus driven during hold");
  chk_hold_release: assert property (hold_ack && !hold_req |=> !hold_ack)
    else $error("hold ack kept after request dropped");
  chk_read_float: assert property (!rd_n && !strobe_oe_n |-> db_oe_n)
    else $error("data bus driven during read");
  chk_wide_port: assert property (wide_output_cmd |=> ext_oe_n == 16'h0000 && ext_pins == {reg_b, reg_c})
    else $error("wide output not on pins");
  chk_first_fetch: assert property ($rose(first_cycle_flag) |-> $past(cyc_start && cyc_opfetch))
    else $error("first cycle flag without opcode fetch");
  chk_wait_stretch: assert property ($fell(rd_n) && !strobe_oe_n && !wait_n |=> !rd_n && !cyc_done)
    else $error("wait not inserted");
  chk_irq_vector: assert property (irq_req |-> irq_pending[irq_vector])
    else $error("vector points at idle request");
  chk_reset_vals: assert property ($rose(resetn) |-> ext_oe_n == 16'hFFFF && db_oe_n && strobe_oe_n
    && serial_ack && !timer_out && !hold_ack && portc_mode == MODEC_RST && portb_dir == MODEB_RST
    && port_a == 8'h00 && irq_pending == 5'h00)
    else $error("reset values wrong");
endmodule : subcpu_pins_chk

bind subcpu_pins subcpu_pins_chk chk (.*);

// ---- verif/mem_model.sv ----
// external memory and slow device across the data bus
`timescale 1ns/1ps
module mem_model (
  // clock
  input wire logic        clk_sys,
  // bus
  input wire logic        rd_n, wr_n, strobe_oe_n,
  input wire logic [15:0] ext_pins,
  input wire logic [3:0]  slow,
  output logic [7:0]      db_in,
  output logic            wait_n
);
  logic       idle, rd_ok;
  logic [7:0] last = 8'h00;
  logic [3:0] cnt;
  assign idle = strobe_oe_n || (rd_n && wr_n);
  assign rd_ok = !strobe_oe_n && !rd_n;
  // hold wait low for slow cycles of each strobe
  always @(posedge clk_sys)
    cnt <= idle ? 4'h0 : cnt + 4'h1;
  assign wait_n = idle || (cnt >= slow);
  always @(posedge clk_sys)
    if (rd_ok)
      last <= ext_pins[7:0] ^ 8'h5A;
  // released bus shows inverse of last value, never a stale match
  assign db_in = rd_ok ? ext_pins[7:0] ^ 8'h5A : ~last;
endmodule : mem_model

// ---- verif/tb.sv ----
// self-checking bench for the pin control block
`timescale 1ns/1ps
module tb;
  import subcpu_pkg::*;
  localparam int TK = 8;
  logic        clk_sys, resetn, ce, reset_pin_n, halt_req, ie_set, ie_clr, irq_taken;
  logic        cyc_start, cyc_mem, cyc_write, cyc_opfetch, timer_start_cmd, timer_load;
  logic        addr_bus_enable_cmd, split_cmd, wide_output_cmd, modec_we, mask_we;
  logic        serial_we, serial_rd, serial_select_n, serial_clock_n, serial_in, hold_req;
  logic        level_irq, rise_irq, edge_sel_irq, wait_n, cyc_done, halted, core_reset;
  logic        irq_req, serial_out, serial_out_oe_n, serial_ack, timer_out, io_not_mem;
  logic        hold_ack, first_cycle_flag, half_clock_out, rd_n, wr_n, strobe_oe_n, db_oe_n;
  logic [15:0] cyc_addr, start_addr, ext_pins, ext_oe_n;
  logic [11:0] timer_value;
  logic [7:0]  cyc_wdata, reg_b, reg_c, modec_wdata, mask_wdata, serial_wdata, db_in;
  logic [7:0]  cyc_rdata, serial_rdata, portb_dir, portc_mode, port_a, db_out;
  logic [4:0]  irq_pending;
  logic [3:0]  slow;
  logic [2:0]  irq_vector;
  int          bad_count, checks, n;

  subcpu_pins #(.SAMPLE_CYCLES(4), .TICK_CYCLES(TK)) DUT (.*);
  mem_model mem (.*);

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task fail;
    bad_count++;
    $display("ERROR at %0t: wait limit reached", $time);
    final_report();
  endtask : fail

  // settle past the edge before looking
  task cy(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : cy

  task do_reset;
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (5) @(posedge clk_sys);
    resetn <= 1'b1;
    n = 0;
    while (core_reset !== 1'b0)
    begin
      if (++n > 200) fail();
      cy(1);
    end
    chk({portc_mode, portb_dir}, 16'hFFFF);
    chk({port_a, 3'b000, irq_pending}, 16'h0000);
    chk({serial_ack, timer_out, hold_ack, db_oe_n, strobe_oe_n, halted}, 6'b100110);
    chk(ext_oe_n, 16'hFFFF);
    chk(start_addr, PC_RST);
    $display("test reset done");
  endtask : do_reset

  task mcyc(input logic mem, wr, op, input logic [15:0] a, input logic [7:0] d,
            input logic [3:0] sl);
    logic seen;
    seen = 1'b0;
    @(posedge clk_sys);
    {cyc_start, cyc_mem, cyc_write, cyc_opfetch} <= {1'b1, mem, wr, op};
    cyc_addr <= a;
    cyc_wdata <= d;
    slow <= sl;
    @(posedge clk_sys);
    cyc_start <= 1'b0;
    n = 0;
    while (cyc_done !== 1'b1)
    begin
      if (++n > 40) fail();
      cy(1);
      if (!seen && (rd_n === 1'b0 || wr_n === 1'b0))
      begin
        seen = 1'b1;
        chk({io_not_mem, first_cycle_flag, rd_n}, {!mem, op, wr});
        if (mem) chk(ext_pins, a);
        chk({db_oe_n, wr ? db_out : 8'h00}, {!wr, wr ? d : 8'h00});
      end
    end
    chk(n, 2 + sl);
    cy(1);
    if (mem && !wr) chk(cyc_rdata, a[7:0] ^ 8'h5A);
  endtask : mcyc

  task sload(input logic [7:0] d);
    @(posedge clk_sys);
    serial_we <= 1'b1;
    serial_wdata <= d;
    @(posedge clk_sys);
    serial_we <= 1'b0;
    cy(2);
  endtask : sload

  // one 200 ns link clock period per bit, idle high between frames
  task frame(input logic [7:0] tx, input logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      @(posedge clk_sys);
      serial_clock_n <= 1'b0;
      serial_in <= rx[i];
      cy(4);
      chk(serial_out, tx[i]);
      @(posedge clk_sys);
      serial_clock_n <= 1'b1;
      cy(2);
    end
    cy(4);
    chk({serial_ack, serial_rdata}, {1'b0, rx});
  endtask : frame

  initial
  begin
    {resetn, halt_req, ie_set, ie_clr, irq_taken, cyc_start, cyc_mem, cyc_write} = 8'h00;
    {cyc_opfetch, timer_start_cmd, timer_load, addr_bus_enable_cmd, split_cmd} = 5'h00;
    {wide_output_cmd, modec_we, mask_we, serial_we, serial_rd, serial_in} = 6'h00;
    {hold_req, level_irq, rise_irq, edge_sel_irq, slow} = 8'h00;
    {ce, reset_pin_n, serial_select_n, serial_clock_n} = 4'hF;
    {cyc_addr, cyc_wdata, modec_wdata, mask_wdata, serial_wdata} = 48'h0;
    {reg_b, reg_c, timer_value} = {8'hA5, 8'h3C, 12'h000};
    bad_count = 0;
    checks = 0;
    do_reset();
    mcyc(1, 0, 1, 16'h1234, 8'h00, 0);
    mcyc(1, 0, 0, 16'hBEEF, 8'h00, 2);
    mcyc(1, 1, 0, 16'h4321, 8'hA6, 3);
    mcyc(0, 0, 0, 16'h00F0, 8'h00, 0);
    mcyc(0, 1, 0, 16'h0011, 8'h5C, 1);
    $display("test bus cycles done");
    @(posedge clk_sys);
    hold_req <= 1'b1;
    cy(3);
    chk({hold_ack, db_oe_n, strobe_oe_n, ext_oe_n}, {3'b111, 16'hFFFF});
    @(posedge clk_sys);
    hold_req <= 1'b0;
    cy(2);
    chk(hold_ack, 1'b0);
    mcyc(1, 0, 0, 16'h2222, 8'h00, 0);
    $display("test hold done");
    @(posedge clk_sys);
    split_cmd <= 1'b1;
    @(posedge clk_sys);
    split_cmd <= 1'b0;
    cy(2);
    chk({ext_oe_n[15:12], ext_pins[15:12], ext_oe_n[11:0]}, 20'h0AFFF);
    mcyc(1, 0, 0, 16'hA123, 8'h00, 1);
    @(posedge clk_sys);
    wide_output_cmd <= 1'b1;
    @(posedge clk_sys);
    wide_output_cmd <= 1'b0;
    cy(2);
    chk({ext_pins, ext_oe_n}, {reg_b, reg_c, 16'h0000});
    @(posedge clk_sys);
    addr_bus_enable_cmd <= 1'b1;
    @(posedge clk_sys);
    addr_bus_enable_cmd <= 1'b0;
    cy(2);
    chk(ext_oe_n, 16'hFFFF);
    $display("test pin modes done");
    @(posedge clk_sys);
    timer_load <= 1'b1;
    timer_value <= 12'h003;
    @(posedge clk_sys);
    timer_load <= 1'b0;
    timer_start_cmd <= 1'b1;
    @(posedge clk_sys);
    timer_start_cmd <= 1'b0;
    cy(1);
    chk(timer_out, 1'b1);
    n = 0;
    while (timer_out !== 1'b0)
    begin
      if (++n > 100) fail();
      cy(1);
    end
    chk(n > TK, 1'b1);
    $display("test timer done");
    sload(8'hC3);
    chk(serial_out_oe_n, 1'b0);
    frame(8'hC3, 8'h3C);
    @(posedge clk_sys);
    modec_we <= 1'b1;
    modec_wdata <= 8'hFB;
    @(posedge clk_sys);
    modec_we <= 1'b0;
    cy(4);
    chk(serial_out_oe_n, 1'b1);
    sload(8'h96);
    @(posedge clk_sys);
    serial_clock_n <= 1'b0;
    cy(4);
    @(posedge clk_sys);
    serial_clock_n <= 1'b1;
    cy(4);
    @(posedge clk_sys);
    serial_select_n <= 1'b0;
    cy(4);
    chk(serial_out_oe_n, 1'b0);
    frame(8'h96, 8'h69);
    @(posedge clk_sys);
    serial_rd <= 1'b1;
    @(posedge clk_sys);
    serial_rd <= 1'b0;
    cy(1);
    chk(serial_ack, 1'b1);
    $display("test serial done");
    @(posedge clk_sys);
    {mask_we, ie_set, mask_wdata} <= {2'b11, 8'h02};
    @(posedge clk_sys);
    {mask_we, ie_set, level_irq, rise_irq} <= 4'b0011;
    cy(30);
    chk({irq_req, irq_vector, irq_pending[2]}, 5'b10001);
    @(posedge clk_sys);
    level_irq <= 1'b0;
    cy(30);
    chk({irq_pending[0], irq_vector}, 4'b0010);
    @(posedge clk_sys);
    {irq_taken, rise_irq} <= 2'b10;
    @(posedge clk_sys);
    irq_taken <= 1'b0;
    cy(30);
    @(posedge clk_sys);
    rise_irq <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rise_irq <= 1'b0;
    cy(30);
    chk(irq_pending[2], 1'b0);
    @(posedge clk_sys);
    edge_sel_irq <= 1'b1;
    cy(30);
    chk(irq_pending[3], 1'b0);
    @(posedge clk_sys);
    edge_sel_irq <= 1'b0;
    cy(30);
    chk(irq_pending[3], 1'b1);
    @(posedge clk_sys);
    {irq_taken, mask_we, mask_wdata} <= {2'b11, 8'h82};
    @(posedge clk_sys);
    {irq_taken, mask_we} <= 2'b00;
    cy(30);
    chk(irq_pending[3], 1'b0);
    @(posedge clk_sys);
    edge_sel_irq <= 1'b1;
    cy(30);
    chk(irq_pending[3], 1'b1);
    $display("test interrupts done");
    @(posedge clk_sys);
    reset_pin_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_pin_n <= 1'b1;
    cy(20);
    chk({core_reset, irq_pending[3]}, 2'b01);
    @(posedge clk_sys);
    halt_req <= 1'b1;
    @(posedge clk_sys);
    halt_req <= 1'b0;
    cy(2);
    chk({halted, strobe_oe_n, db_oe_n, ext_oe_n}, {3'b111, 16'hFFFF});
    $display("test glitch and halt done");
    do_reset();
    final_report();
  end
endmodule : tb
